/* File: core/dm_if.sv */
// carrier between the register bank and one channel's drive monitor
// assumes all signals are already in the mclk domain
`timescale 1ns/1ps
interface dm_if;
	logic select;
	logic pad_pos;
	logic pad_neg;
	logic mon_pos;
	logic mon_neg;
	logic tick;
	logic alarm;
	modport monitor (
		input  select,
		input  pad_pos,
		input  pad_neg,
		input  mon_pos,
		input  mon_neg,
		input  tick,
		output alarm
	);
	modport owner (
		output select,
		output pad_pos,
		output pad_neg,
		output mon_pos,
		output mon_neg,
		output tick,
		input  alarm
	);
endinterface

/* File: core/drive_monitor.sv */
// transmit drive monitor for one channel
// assumes synchronised line levels and a one-cycle tick per bit period
`timescale 1ns/1ps
module drive_monitor (
	input wire logic mclk,
	input wire logic rst_n,
	dm_if.monitor    dm
);
	localparam int CW = $clog2(txc_pkg::DM_QUIET_BITS) + 1;
	localparam logic [CW-1:0] LAST =
		CW'(txc_pkg::DM_QUIET_BITS - 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          alarm;
	} dm_state_s;

	dm_state_s st_r;
	dm_state_s st_nxt;
	logic      pulse;

	always_comb begin
		st_nxt = st_r;
		pulse = dm.mon_pos | dm.mon_neg;
		if (dm.select) begin
			pulse = dm.pad_pos | dm.pad_neg;
		end
		if (dm.tick) begin
			if (pulse) begin
				st_nxt.cnt   = '0;
				st_nxt.alarm = 1'b0;
			end else if (st_r.cnt == LAST) begin
				st_nxt.alarm = 1'b1;
			end else begin
				st_nxt.cnt = st_r.cnt + CW'(1);
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign dm.alarm = st_r.alarm;
endmodule

/* File: core/tx_channel_control_reg.sv */
// per-channel transmit control registers with drive monitors
// assumes asynchronous host strobes and line pins, all synchronised here
// assumes each line clock runs below a quarter of mclk
//
// Function
// - one 8-bit register per channel, 0xm4
// - bit 5 selects drive monitor source
// - bit 5 low: watch external monitor pair
// - bit 5 high: watch pads, ignore monitors
// - bit 4 rise inverts one PRBS bit
// - insert ignored unless PRBS gen, rx enabled
// - alarm after 128 quiet bits, clear on pulse
// - bit 2 sends unframed all ones
// - bit 1 picks transmit sampling edge
`timescale 1ns/1ps
module tx_channel_control_reg #(
	parameter int CHANNELS = 12
) (
	input  wire logic                mclk,
	input  wire logic                rstn,
	input  wire logic                cs_n,
	input  wire logic                wr_n,
	input  wire logic                rd_n,
	input  wire logic [7:0]          addr,
	input  wire logic [7:0]          data_in,
	output wire logic [7:0]          data_out,
	output wire logic                data_oe,
	input  wire logic [CHANNELS-1:0] tx_line_clock,
	input  wire logic [CHANNELS-1:0] line_out_positive,
	input  wire logic [CHANNELS-1:0] line_out_negative,
	input  wire logic [CHANNELS-1:0] monitor_in_positive,
	input  wire logic [CHANNELS-1:0] monitor_in_negative,
	input  wire logic [CHANNELS-1:0] prbs_gen_enable,
	input  wire logic [CHANNELS-1:0] prbs_rx_enable,
	output wire logic [CHANNELS-1:0] prbs_error_insert,
	output wire logic [CHANNELS-1:0] drive_monitor_alarm,
	output wire logic [CHANNELS-1:0] send_all_ones,
	output wire logic [CHANNELS-1:0] tx_sample_edge_select,
	output wire logic [CHANNELS-1:0] tx_pulse_shaping_select
);
	if (CHANNELS < 1 || CHANNELS > txc_pkg::MAX_CHANNELS) begin : g_chk
		$error("CHANNELS must lie between 1 and 16");
	end

	// layout of the synchronised pin vector: port pins, then channels
	localparam int P_CS   = 0;
	localparam int P_WR   = 1;
	localparam int P_RD   = 2;
	localparam int P_ADDR = 3;
	localparam int P_DATA = P_ADDR + txc_pkg::ADDR_W;
	localparam int P_CH   = P_DATA + txc_pkg::DATA_W;

	// order of one channel's pins inside its slice
	localparam int O_CLK  = 0;
	localparam int O_PADP = 1;
	localparam int O_PADN = 2;
	localparam int O_MONP = 3;
	localparam int O_MONN = 4;
	localparam int PER_CH = O_MONN + 1;
	localparam int PW     = P_CH + PER_CH * CHANNELS;

	// every flop of the bank but the drive monitors'; the reset synchroniser stays outside
	// because it drives this struct's own reset
	typedef struct packed {
		logic [PW-1:0]                     s1;
		logic [PW-1:0]                     s2;
		logic                              wr_prev;
		logic [CHANNELS-1:0]               clk_prev;
		logic [CHANNELS-1:0]               tick;
		logic [CHANNELS-1:0][7:0]          ctrl;
		logic [CHANNELS-1:0]               err_pulse;
		logic [7:0]                        rdata;
		logic                              oe;
	} bank_state_s;

	bank_state_s         st_r;
	bank_state_s         st_nxt;
	logic                rst_s1;
	logic                rst_n_sync;
	logic [PW-1:0]       pins;
	logic [7:0]          a_s;
	logic [7:0]          d_s;
	logic                wr_go;
	logic                rd_on;
	logic [7:0]          new_val;
	logic [CHANNELS-1:0] ins_arm;

	// high nibble selects the channel, low nibble the register;
	// channels past CHANNELS never match, so such reads return nothing
	function automatic logic chan_hit(input logic [7:0] a, input int c);
		chan_hit = (a[3:0] == txc_pkg::CTRL_SUBADDR) &&
			(a[7:4] == 4'(c));
	endfunction

	// index of pin k of channel c in the synchronised vector
	function automatic int pin_at(input int c, input int k);
		pin_at = P_CH + PER_CH * c + k;
	endfunction

	// reset asserts at once but leaves two edges late, so no flop of
	// the bank sees its release close to a clock edge
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rst_s1     <= 1'b0;
			rst_n_sync <= 1'b0;
		end else begin
			rst_s1     <= 1'b1;
			rst_n_sync <= rst_s1;
		end
	end

	// every pin passes s1 then s2; only s2 is read, s1 may be metastable
	always_comb begin
		pins                             = '0;
		pins[P_CS]                       = cs_n;
		pins[P_WR]                       = wr_n;
		pins[P_RD]                       = rd_n;
		pins[P_DATA-1:P_ADDR]            = addr;
		pins[P_CH-1:P_DATA]              = data_in;
		for (int c = 0; c < CHANNELS; c++) begin
			pins[pin_at(c, O_CLK)]  = tx_line_clock[c];
			pins[pin_at(c, O_PADP)] = line_out_positive[c];
			pins[pin_at(c, O_PADN)] = line_out_negative[c];
			pins[pin_at(c, O_MONP)] = monitor_in_positive[c];
			pins[pin_at(c, O_MONN)] = monitor_in_negative[c];
		end
	end

	// address and data ride the same stages as the strobe; the host must
	// hold them steady before the strobe falls or a torn value is stored
	assign a_s   = st_r.s2[P_DATA-1:P_ADDR];
	assign d_s   = st_r.s2[P_CH-1:P_DATA];
	// a write is taken once, on the falling edge of the strobe
	assign wr_go = !st_r.s2[P_CS] && !st_r.s2[P_WR] && st_r.wr_prev;
	assign rd_on = !st_r.s2[P_CS] && !st_r.s2[P_RD];
	assign new_val = d_s & txc_pkg::CTRL_RW_MASK;
	assign ins_arm = prbs_gen_enable & prbs_rx_enable;

	always_comb begin
		st_nxt           = st_r;
		st_nxt.s1        = pins;
		st_nxt.s2        = st_r.s1;
		st_nxt.wr_prev   = st_r.s2[P_WR];
		st_nxt.err_pulse = '0;
		st_nxt.rdata     = '0;
		st_nxt.oe        = 1'b0;
		for (int c = 0; c < CHANNELS; c++) begin
			// one tick per rising edge of the line clock; a line clock
			// above a quarter of mclk would lose edges here
			st_nxt.clk_prev[c] = st_r.s2[pin_at(c, O_CLK)];
			st_nxt.tick[c] = st_r.s2[pin_at(c, O_CLK)] &&
				!st_r.clk_prev[c];
			if (wr_go && chan_hit(a_s, c)) begin
				st_nxt.ctrl[c] = new_val;
				// rising edge only
				// judged on the stored bit: a rise refused while the
				// PRBS ends are off is not replayed when they turn on
				if (!st_r.ctrl[c][txc_pkg::BIT_ERR_INS] &&
					new_val[txc_pkg::BIT_ERR_INS] && ins_arm[c]) begin
					st_nxt.err_pulse[c] = 1'b1;
				end
			end
			// channel register read, zero when not driving
			if (rd_on && chan_hit(a_s, c)) begin
				st_nxt.rdata = st_r.ctrl[c];
				st_nxt.oe    = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			st_r          <= '0;
			// strobes start idle high so no false write follows reset
			st_r.s1[P_CS] <= 1'b1;
			st_r.s1[P_WR] <= 1'b1;
			st_r.s1[P_RD] <= 1'b1;
			st_r.s2[P_CS] <= 1'b1;
			st_r.s2[P_WR] <= 1'b1;
			st_r.s2[P_RD] <= 1'b1;
			st_r.wr_prev  <= 1'b1;
			st_r.ctrl     <= {CHANNELS{txc_pkg::CTRL_RESET}};
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs come straight from the state flops
	assign data_out          = st_r.rdata;
	assign data_oe           = st_r.oe;
	assign prbs_error_insert = st_r.err_pulse;

	for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
		// one drive monitor per channel, fed from the second sync stage
		dm_if dmi ();
		assign dmi.select  = st_r.ctrl[c][txc_pkg::BIT_INT_MON];
		assign dmi.pad_pos = st_r.s2[pin_at(c, O_PADP)];
		assign dmi.pad_neg = st_r.s2[pin_at(c, O_PADN)];
		assign dmi.mon_pos = st_r.s2[pin_at(c, O_MONP)];
		assign dmi.mon_neg = st_r.s2[pin_at(c, O_MONN)];
		assign dmi.tick    = st_r.tick[c];
		drive_monitor u_dm (
			.mclk  (mclk),
			.rst_n (rst_n_sync),
			.dm    (dmi.monitor)
		);
		assign drive_monitor_alarm[c] = dmi.alarm;
		assign send_all_ones[c] = st_r.ctrl[c][txc_pkg::BIT_ALL_ONES];
		assign tx_sample_edge_select[c] =
			st_r.ctrl[c][txc_pkg::BIT_EDGE_SEL];

		// pulse shaping choice is only passed on to the line driver
		assign tx_pulse_shaping_select[c] =
			st_r.ctrl[c][txc_pkg::BIT_SHAPING];
	end
endmodule

/* File: core/txc_pkg.sv */
// constants for the per-channel transmit control register bank
// assumes an 8-bit parallel microprocessor port with channel in addr[7:4]
package txc_pkg;
	localparam int          DATA_W        = 8;
	localparam int          ADDR_W        = 8;
	localparam int          MAX_CHANNELS  = 16;
	localparam logic [3:0]  CTRL_SUBADDR  = 4'h4;
	localparam logic [7:0]  CTRL_RESET    = 8'h00;
	// bits 7, 6 and 3 are reserved and never stored
	localparam logic [7:0]  CTRL_RW_MASK  = 8'h37;
	localparam int          BIT_SHAPING   = 0;
	localparam int          BIT_EDGE_SEL  = 1;
	localparam int          BIT_ALL_ONES  = 2;
	localparam int          BIT_ERR_INS   = 4;
	localparam int          BIT_INT_MON   = 5;
	// bit periods without a bipolar pulse before the alarm is raised
	localparam int          DM_QUIET_BITS = 128;
endpackage

/* File: tb/host.sv */
// host processor model on the parallel port
// assumes strobes may change 1 ns after a mclk edge
`timescale 1ns/1ps
module host (
	input  wire logic       mclk,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe,
	output logic            cs_n,
	output logic            wr_n,
	output logic            rd_n,
	output logic [7:0]      addr,
	output logic [7:0]      data_in
);
	initial {cs_n, wr_n, rd_n, addr, data_in} = {3'h7, 16'h0000};
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk) #1;
		{addr, data_in, cs_n} = {a, d, 1'b0};
		repeat (4) @(posedge mclk);
		#1 wr_n = 1'b0;
		repeat (6) @(posedge mclk);
		#1 wr_n = 1'b1;
		@(posedge mclk) #1;
		// released bus shows a changed value, not the last one
		{cs_n, data_in} = {1'b1, ~d};
		repeat (4) @(posedge mclk);
		#1;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d, output logic oe);
		@(posedge mclk) #1;
		{addr, cs_n, rd_n} = {a, 2'h0};
		repeat (6) @(posedge mclk);
		#1 {d, oe} = {data_out, data_oe};
		{cs_n, rd_n} = 2'h3;
		repeat (5) @(posedge mclk);
		#1;
	endtask
endmodule

/* File: tb/tb.sv */
// self-checking bench of the transmit control bank
// assumes host drives the port and this bench drives the line pins
`timescale 1ns/1ps
module tb;
	localparam int CH = 2;
	logic          mclk, rstn, cs_n, wr_n, rd_n, data_oe;
	logic [7:0]    addr, data_in, data_out, rv;
	logic [CH-1:0] tx_line_clock, line_out_positive, line_out_negative;
	logic [CH-1:0] monitor_in_positive, monitor_in_negative;
	logic [CH-1:0] prbs_gen_enable, prbs_rx_enable, prbs_error_insert;
	logic [CH-1:0] drive_monitor_alarm, send_all_ones;
	logic [CH-1:0] tx_sample_edge_select, tx_pulse_shaping_select;
	logic          oe;
	int            fail_count, compares;
	int            ins_cnt = 0;
	tx_channel_control_reg #(.CHANNELS(CH)) dut (.*);
	host h (.*);
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// line clock well below a quarter of mclk
	initial begin
		tx_line_clock = '0;
		forever begin
			repeat (4) @(posedge mclk);
			#1 tx_line_clock = ~tx_line_clock;
		end
	end
	always @(posedge mclk) if (prbs_error_insert[0] === 1'b1) ins_cnt++;
	task check(input string nm, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task rdc(input logic [7:0] a, input logic [7:0] e, input logic eo);
		h.rd(a, rv, oe);
		check("read data", e, rv);
		check("read enable", {7'h00, eo}, {7'h00, oe});
	endtask
	task alm(input int n, input logic e);
		repeat (n) @(posedge mclk);
		#1 check("alarm", {7'h00, e}, {7'h00, drive_monitor_alarm[0]});
	endtask
	task final_report;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// the tests need about 4000 cycles
	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		final_report();
	end
	initial begin
		{rstn, fail_count, compares} = '0;
		{line_out_positive, line_out_negative} = '0;
		{monitor_in_positive, monitor_in_negative} = '0;
		{prbs_gen_enable, prbs_rx_enable} = '0;
		repeat (3) @(posedge mclk);
		#1 rstn = 1'b1;
		repeat (3) @(posedge mclk);
		rdc(8'h04, 8'h00, 1'b1);
		check("outputs", 8'h00, {send_all_ones, tx_sample_edge_select,
			tx_pulse_shaping_select, drive_monitor_alarm});
		h.wr(8'h04, 8'hFF);
		rdc(8'h04, 8'h37, 1'b1);
		check("outputs", 8'h54, {send_all_ones, tx_sample_edge_select,
			tx_pulse_shaping_select, drive_monitor_alarm});
		rdc(8'h14, 8'h00, 1'b1);
		rdc(8'h05, 8'h00, 1'b0);
		rdc(8'h24, 8'h00, 1'b0);
		check("inserts", 8'h00, 8'(ins_cnt));
		{prbs_gen_enable, prbs_rx_enable} = 4'hF;
		h.wr(8'h04, 8'h00);
		h.wr(8'h04, 8'h10);
		check("inserts", 8'h01, 8'(ins_cnt));
		h.wr(8'h04, 8'h10);
		check("inserts", 8'h01, 8'(ins_cnt));
		h.wr(8'h04, 8'h00);
		h.wr(8'h04, 8'h10);
		check("inserts", 8'h02, 8'(ins_cnt));
		prbs_rx_enable = 2'h0;
		h.wr(8'h04, 8'h00);
		h.wr(8'h04, 8'h10);
		check("inserts", 8'h02, 8'(ins_cnt));
		{prbs_gen_enable, prbs_rx_enable} = 4'h3;
		h.wr(8'h04, 8'h00);
		h.wr(8'h04, 8'h10);
		check("inserts", 8'h02, 8'(ins_cnt));
		h.wr(8'h04, 8'h00);
		alm(1100, 1'b1);
		line_out_positive = 2'h1;
		alm(100, 1'b1);
		monitor_in_positive = 2'h1;
		alm(40, 1'b0);
		monitor_in_positive = 2'h0;
		alm(950, 1'b0);
		alm(150, 1'b1);
		h.wr(8'h04, 8'h20);
		alm(40, 1'b0);
		{monitor_in_positive, line_out_positive} = 4'h4;
		alm(1150, 1'b1);
		line_out_negative = 2'h1;
		alm(40, 1'b0);
		final_report();
	end
endmodule
bind tx_channel_control_reg txc_chk #(.CHANNELS(CHANNELS)) chk (.*);

/* File: tb/txc_chk.sv */
// port checker of the transmit control bank
// assumes binding to the top module
`timescale 1ns/1ps
module txc_chk #(
	parameter int CHANNELS = 12
) (
	input wire logic                mclk,
	input wire logic                rstn,
	input wire logic                wr_n,
	input wire logic                rd_n,
	input wire logic [7:0]          data_out,
	input wire logic                data_oe,
	input wire logic [CHANNELS-1:0] line_out_positive,
	input wire logic [CHANNELS-1:0] line_out_negative,
	input wire logic [CHANNELS-1:0] monitor_in_positive,
	input wire logic [CHANNELS-1:0] monitor_in_negative,
	input wire logic [CHANNELS-1:0] prbs_gen_enable,
	input wire logic [CHANNELS-1:0] prbs_rx_enable,
	input wire logic [CHANNELS-1:0] prbs_error_insert,
	input wire logic [CHANNELS-1:0] drive_monitor_alarm,
	input wire logic [CHANNELS-1:0] send_all_ones,
	input wire logic [CHANNELS-1:0] tx_sample_edge_select,
	input wire logic [CHANNELS-1:0] tx_pulse_shaping_select
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);

	property p_rsv_zero;
		data_oe |-> (data_out & 8'hC8) == 8'h00;
	endproperty
	property p_ins_one;
		prbs_error_insert[0] |=> !prbs_error_insert[0];
	endproperty
	property p_ins_en;
		prbs_error_insert[0] |-> prbs_gen_enable[0] && prbs_rx_enable[0];
	endproperty
	property p_cfg_hold;
		wr_n [*6] |=> $stable({send_all_ones, tx_sample_edge_select,
			tx_pulse_shaping_select});
	endproperty
	// sync stages delay a clear, hence the eight quiet cycles
	property p_alm_hold;
		(drive_monitor_alarm[0] && !(line_out_positive[0] |
			line_out_negative[0] | monitor_in_positive[0] |
			monitor_in_negative[0])) [*8] |=> drive_monitor_alarm[0];
	endproperty

	AST_OE_ZERO: assert property (!data_oe |-> data_out == 8'h00)
		else $error("read data seen while idle");
	AST_OE_RD: assert property (rd_n [*5] |=> !data_oe)
		else $error("read data without a read");
	AST_RSV_ZERO: assert property (p_rsv_zero)
		else $error("reserved bits read nonzero");
	AST_INS_ONE: assert property (p_ins_one)
		else $error("insert pulse longer than one cycle");
	AST_INS_WR: assert property (prbs_error_insert[0] |-> !wr_n)
		else $error("insert pulse outside a write");
	AST_INS_EN: assert property (p_ins_en)
		else $error("insert while prbs disabled");
	AST_CFG_HOLD: assert property (p_cfg_hold)
		else $error("control outputs moved without a write");
	AST_ALM_HOLD: assert property (p_alm_hold)
		else $error("alarm cleared without activity");
	cover property ($rose(drive_monitor_alarm[0]));
	cover property ($fell(drive_monitor_alarm[0]));
	cover property (prbs_error_insert[0]);
	cover property (data_oe && data_out[5]);
endmodule
